/* logic/ext_decode_core.sv */
// Decode and execute core for the negate, idle and extended instructions.
// Assumes a Wishbone classic master and one core clock with four phases
// per instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module ext_decode_core
    import ext_decode_pkg::*;
#(
    parameter int STACK_DEPTH = 31,
    parameter int RAM_BYTES = 4096
)(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic ack_o,
    output logic [31:0] dat_o
);
    localparam int AW = $clog2(RAM_BYTES);
    localparam int SW = $clog2(STACK_DEPTH + 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    st_e state_ff, nxt_state;
    logic [1:0] qPh_ff, nxt_qPh, ptrSel;
    logic [15:0] word1_ff, nxt_word1, word2_ff, nxt_word2;
    logic xen_ff, nxt_xen, ill_ff, nxt_ill;
    logic [7:0] work_ff, nxt_work, hold_ff, nxt_hold, cnt_ff, nxt_cnt;
    logic [5:0] bank_ff, nxt_bank;
    flags_s flags_ff, nxt_flags;
    logic [11:0] ptr_ff [3];
    logic [11:0] nxt_ptr [3];
    logic [20:0] pc_ff, nxt_pc;
    logic [12:0] pclat_ff, nxt_pclat;
    logic [SW-1:0] sp_ff, nxt_sp;
    logic [11:0] dadr_ff, nxt_dadr;
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic [7:0] ram [RAM_BYTES];
    logic [20:0] stk [STACK_DEPTH];

    dec_s dec;
    logic [11:0] fileAddr, srcAddr, dstAddr, rdAddr, ramWAddr;
    logic [7:0] rdByte, negRes, ramWData;
    logic ramWe, stkWe, isIdx, wrStb, rdStb;
    logic [20:0] stkWData, tos;
    flags_s negFlg;
    logic [31:0] rdVal, mask, merged;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    always_comb begin
        dec.ptr = word1_ff[7:6];
        ptrSel = (dec.ptr == PTR_TWO_SEL) ? 2'h2 : dec.ptr;
        dec.lit = {2'h0, word1_ff[5:0]};
        dec.op = OP_ILLEGAL;
        if (word1_ff == OPC_IDLE || word1_ff[15:12] == SECOND_NIB) begin
            dec.op = OP_IDLE;
        end else if (word1_ff[15:9] == OPC_NEGATE) begin
            dec.op = OP_NEGATE;
        end else if (xen_ff) begin
            if (word1_ff[15:8] == OPC_ADDPTR) begin
                dec.op = (dec.ptr == PTR_TWO_SEL) ? OP_ADDRET : OP_ADDPTR;
            end else if (word1_ff[15:8] == OPC_SUBPTR) begin
                dec.op = (dec.ptr == PTR_TWO_SEL) ? OP_SUBRET : OP_SUBPTR;
            end else if (word1_ff == OPC_CALLWORK) begin
                dec.op = OP_CALLWORK;
            end else if (word1_ff[15:8] == OPC_PUSH) begin
                dec.op = OP_PUSH;
                dec.lit = word1_ff[7:0];
            end else if (word1_ff[15:8] == OPC_MOVE &&
                         word2_ff[15:12] == SECOND_NIB) begin
                dec.op = word1_ff[7] ? OP_MOVES : OP_MOVEF;
            end
        end
        dec.twoCyc = dec.op inside {OP_ADDRET, OP_SUBRET, OP_CALLWORK,
                                    OP_MOVEF, OP_MOVES};
    end

    addr_resolve u_resolve (
        .fileOpnd(word1_ff[7:0]),
        .accessSel(word1_ff[8]),
        .bankSel(bank_ff),
        .ptrTwo(ptr_ff[2]),
        .extEn(xen_ff),
        .dataAddr(fileAddr),
        .indexed(isIdx)
    );

    negate_unit u_negate (
        .opnd(rdByte),
        .res(negRes),
        .flg(negFlg)
    );

    // ------------------------------------------------------------------
    // Data memory and return stack
    // ------------------------------------------------------------------
    always_comb begin
        srcAddr = 12'(ptr_ff[2] + {5'h00, word1_ff[6:0]});
        if (dec.op == OP_MOVES) begin
            dstAddr = 12'(ptr_ff[2] + {5'h00, word2_ff[6:0]});
        end else begin
            dstAddr = word2_ff[11:0];
        end
        if (state_ff == ST_IDLE) begin
            rdAddr = dadr_ff;
        end else if (dec.op == OP_MOVEF || dec.op == OP_MOVES) begin
            rdAddr = srcAddr;
        end else begin
            rdAddr = fileAddr;
        end
        rdByte = ram[rdAddr[AW-1:0]];
        tos = (sp_ff == '0) ? RST_PC : stk[SW'(sp_ff - 1'b1)];
    end

    always_ff @(posedge core_clk) begin
        if (ramWe) begin
            ram[ramWAddr[AW-1:0]] <= ramWData;
        end
        if (stkWe) begin
            stk[sp_ff] <= stkWData;
        end
    end

    // ------------------------------------------------------------------
    // Register read mux and byte lane merge
    // ------------------------------------------------------------------
    always_comb begin
        wrStb = cyc_i && stb_i && we_i && !ack_ff;
        rdStb = cyc_i && stb_i && !we_i && !ack_ff;
        mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        case ({adr_i[7:2], 2'b00})
            OFS_CTRL: rdVal = {30'h0, xen_ff, 1'b0};
            OFS_STAT: rdVal = {16'h0, cnt_ff, 6'h00, ill_ff,
                               state_ff != ST_IDLE};
            OFS_WORD1: rdVal = {16'h0, word1_ff};
            OFS_WORD2: rdVal = {16'h0, word2_ff};
            OFS_WORK: rdVal = {24'h0, work_ff};
            OFS_BANK: rdVal = {26'h0, bank_ff};
            OFS_FLAGS: rdVal = {27'h0, flags_ff};
            OFS_PTR0: rdVal = {20'h0, ptr_ff[0]};
            OFS_PTR1: rdVal = {20'h0, ptr_ff[1]};
            OFS_PTR2: rdVal = {20'h0, ptr_ff[2]};
            OFS_PC: rdVal = {11'h0, pc_ff};
            OFS_PCLAT: rdVal = {19'h0, pclat_ff};
            OFS_STACK: rdVal = {3'h0, 5'(sp_ff), 3'h0, tos};
            OFS_DADDR: rdVal = {20'h0, dadr_ff};
            OFS_DDATA: rdVal = {24'h0, rdByte};
            default: rdVal = 32'h00000000;
        endcase
        merged = (rdVal & ~mask) | (dat_i & mask);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_qPh = qPh_ff;
        nxt_word1 = word1_ff;
        nxt_word2 = word2_ff;
        nxt_xen = xen_ff;
        nxt_ill = ill_ff;
        nxt_work = work_ff;
        nxt_hold = hold_ff;
        nxt_cnt = cnt_ff;
        nxt_bank = bank_ff;
        nxt_flags = flags_ff;
        nxt_ptr = ptr_ff;
        nxt_pc = pc_ff;
        nxt_pclat = pclat_ff;
        nxt_sp = sp_ff;
        nxt_dadr = dadr_ff;
        nxt_ack = cyc_i && stb_i && !ack_ff;
        nxt_rdat = rdStb ? rdVal : rdat_ff;
        ramWe = 1'b0;
        ramWAddr = fileAddr;
        ramWData = negRes;
        stkWe = 1'b0;
        stkWData = 21'(pc_ff + PC_STEP);

        // Writes arriving while an instruction runs are dropped so that
        // software can never tear state the datapath is using.
        if (wrStb && state_ff == ST_IDLE) begin
            case ({adr_i[7:2], 2'b00})
                OFS_CTRL: begin
                    nxt_xen = merged[CTRL_XEN_BIT];
                    if (merged[CTRL_GO_BIT]) begin
                        nxt_state = ST_CYC1;
                        nxt_qPh = 2'h0;
                        nxt_cnt = 8'h00;
                        nxt_ill = 1'b0;
                    end
                end
                OFS_WORD1: nxt_word1 = merged[15:0];
                OFS_WORD2: nxt_word2 = merged[15:0];
                OFS_WORK: nxt_work = merged[7:0];
                OFS_BANK: nxt_bank = merged[5:0];
                OFS_FLAGS: nxt_flags = merged[4:0];
                OFS_PTR0: nxt_ptr[0] = merged[11:0];
                OFS_PTR1: nxt_ptr[1] = merged[11:0];
                OFS_PTR2: nxt_ptr[2] = merged[11:0];
                OFS_PC: nxt_pc = merged[20:0];
                OFS_PCLAT: nxt_pclat = merged[12:0];
                OFS_STACK: begin
                    if (sp_ff < SW'(STACK_DEPTH)) begin
                        stkWe = 1'b1;
                        stkWData = merged[20:0];
                        nxt_sp = SW'(sp_ff + 1'b1);
                    end
                end
                OFS_DADDR: nxt_dadr = merged[11:0];
                OFS_DDATA: begin
                    ramWe = 1'b1;
                    ramWAddr = dadr_ff;
                    ramWData = merged[7:0];
                end
                default: ;
            endcase
        end

        if (state_ff != ST_IDLE) begin
            nxt_qPh = 2'(qPh_ff + 1'b1);
            nxt_cnt = 8'(cnt_ff + 1'b1);
        end

        // All effects land on the last phase of an instruction cycle.
        if (state_ff == ST_CYC1 && qPh_ff == Q_LAST) begin
            nxt_state = dec.twoCyc ? ST_CYC2 : ST_IDLE;
            nxt_pc = 21'(pc_ff + PC_STEP);
            case (dec.op)
                OP_NEGATE: begin
                    ramWe = 1'b1;
                    nxt_flags = negFlg;
                end
                OP_ADDPTR, OP_ADDRET: begin
                    nxt_ptr[ptrSel] = 12'(ptr_ff[ptrSel] +
                                          {4'h0, dec.lit});
                end
                OP_SUBPTR, OP_SUBRET: begin
                    nxt_ptr[ptrSel] = 12'(ptr_ff[ptrSel] -
                                          {4'h0, dec.lit});
                end
                OP_CALLWORK: begin
                    if (sp_ff < SW'(STACK_DEPTH)) begin
                        stkWe = 1'b1;
                        nxt_sp = SW'(sp_ff + 1'b1);
                    end
                    nxt_pc = {pclat_ff, work_ff};
                end
                OP_MOVEF, OP_MOVES: nxt_hold = rdByte;
                OP_PUSH: begin
                    ramWe = 1'b1;
                    ramWAddr = ptr_ff[2];
                    ramWData = dec.lit;
                    nxt_ptr[2] = 12'(ptr_ff[2] - 12'h001);
                end
                OP_ILLEGAL: nxt_ill = 1'b1;
                default: ;
            endcase
        end

        if (state_ff == ST_CYC2 && qPh_ff == Q_LAST) begin
            nxt_state = ST_IDLE;
            case (dec.op)
                OP_ADDRET, OP_SUBRET: begin
                    nxt_pc = tos;
                    if (sp_ff != '0) begin
                        nxt_sp = SW'(sp_ff - 1'b1);
                    end
                end
                OP_MOVEF, OP_MOVES: begin
                    ramWe = 1'b1;
                    ramWAddr = dstAddr;
                    ramWData = hold_ff;
                    nxt_pc = 21'(pc_ff + PC_STEP);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            qPh_ff <= 2'h0;
            word1_ff <= RST_WORD;
            word2_ff <= RST_WORD;
            xen_ff <= RST_XEN;
            ill_ff <= 1'b0;
            work_ff <= RST_BYTE;
            hold_ff <= RST_BYTE;
            cnt_ff <= RST_BYTE;
            bank_ff <= 6'h00;
            flags_ff <= '0;
            ptr_ff <= '{RST_PTR, RST_PTR, RST_PTR};
            pc_ff <= RST_PC;
            pclat_ff <= 13'h0000;
            sp_ff <= '0;
            dadr_ff <= RST_PTR;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            qPh_ff <= nxt_qPh;
            word1_ff <= nxt_word1;
            word2_ff <= nxt_word2;
            xen_ff <= nxt_xen;
            ill_ff <= nxt_ill;
            work_ff <= nxt_work;
            hold_ff <= nxt_hold;
            cnt_ff <= nxt_cnt;
            bank_ff <= nxt_bank;
            flags_ff <= nxt_flags;
            ptr_ff <= nxt_ptr;
            pc_ff <= nxt_pc;
            pclat_ff <= nxt_pclat;
            sp_ff <= nxt_sp;
            dadr_ff <= nxt_dadr;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = rdat_ff;
endmodule
`default_nettype wire

/* logic/ext_decode_pkg.sv */
// Shared constants, types and register map of the extended decode core.
// Assumes a single 100 MHz core clock and a Wishbone classic master.
package ext_decode_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_WORD1 = 8'h08;
    localparam logic [7:0] OFS_WORD2 = 8'h0C;
    localparam logic [7:0] OFS_WORK = 8'h10;
    localparam logic [7:0] OFS_BANK = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    localparam logic [7:0] OFS_PTR0 = 8'h1C;
    localparam logic [7:0] OFS_PTR1 = 8'h20;
    localparam logic [7:0] OFS_PTR2 = 8'h24;
    localparam logic [7:0] OFS_PC = 8'h28;
    localparam logic [7:0] OFS_PCLAT = 8'h2C;
    localparam logic [7:0] OFS_STACK = 8'h30;
    localparam logic [7:0] OFS_DADDR = 8'h34;
    localparam logic [7:0] OFS_DDATA = 8'h38;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_XEN_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ILL_BIT = 1;
    localparam int STAT_CNT_LSB = 8;
    localparam int STACK_PTR_LSB = 24;
    localparam logic RST_XEN = 1'b0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_PTR = 12'h000;
    localparam logic [20:0] RST_PC = 21'h000000;

    // ------------------------------------------------------------------
    // Encodings and addressing constants
    // ------------------------------------------------------------------
    localparam logic [6:0] OPC_NEGATE = 7'h36;
    localparam logic [7:0] OPC_ADDPTR = 8'hE8;
    localparam logic [7:0] OPC_SUBPTR = 8'hE9;
    localparam logic [7:0] OPC_PUSH = 8'hEA;
    localparam logic [7:0] OPC_MOVE = 8'hEB;
    localparam logic [15:0] OPC_CALLWORK = 16'h0014;
    localparam logic [15:0] OPC_IDLE = 16'h0000;
    localparam logic [3:0] SECOND_NIB = 4'hF;
    localparam logic [1:0] PTR_TWO_SEL = 2'h3;
    localparam logic [7:0] INDEX_MAX = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [11:0] ACCESS_HI_BASE = 12'hF00;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] PC_STEP2 = 21'h000004;
    localparam logic [1:0] Q_LAST = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_IDLE = 4'b0000,
        OP_NEGATE = 4'b0001,
        OP_ADDPTR = 4'b0010,
        OP_SUBPTR = 4'b0011,
        OP_ADDRET = 4'b0100,
        OP_SUBRET = 4'b0101,
        OP_CALLWORK = 4'b0110,
        OP_MOVEF = 4'b0111,
        OP_MOVES = 4'b1000,
        OP_PUSH = 4'b1001,
        OP_ILLEGAL = 4'b1010
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CYC1 = 2'b01,
        ST_CYC2 = 2'b10
    } st_e;

    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic dcarry;
        logic carry;
    } flags_s;

    typedef struct packed {
        op_e op;
        logic [1:0] ptr;
        logic [7:0] lit;
        logic twoCyc;
    } dec_s;

endpackage

/* logic/addr_resolve.sv */
// Resolves the data address of a file operand.
// Assumes the bank and pointer values come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module addr_resolve
    import ext_decode_pkg::*;
(
    input wire logic [7:0] fileOpnd,
    input wire logic accessSel,
    input wire logic [5:0] bankSel,
    input wire logic [11:0] ptrTwo,
    input wire logic extEn,
    output logic [11:0] dataAddr,
    output logic indexed
);
    always_comb begin
        indexed = 1'b0;
        if (accessSel) begin
            dataAddr = {bankSel[3:0], fileOpnd};
        end else if (extEn && fileOpnd <= INDEX_MAX) begin
            indexed = 1'b1;
            dataAddr = 12'(ptrTwo + {4'h0, fileOpnd});
        end else if (fileOpnd < ACCESS_SPLIT) begin
            dataAddr = {4'h0, fileOpnd};
        end else begin
            dataAddr = ACCESS_HI_BASE | {4'h0, fileOpnd};
        end
    end
endmodule
`default_nettype wire

/* logic/negate_unit.sv */
// Two's complement of a byte together with the arithmetic flags.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module negate_unit
    import ext_decode_pkg::*;
(
    input wire logic [7:0] opnd,
    output logic [7:0] res,
    output flags_s flg
);
    always_comb begin
        res = 8'(~opnd + 8'h01);
        flg.neg = res[7];
        flg.zero = (res == 8'h00);
        flg.carry = (opnd == 8'h00);
        flg.dcarry = (opnd[3:0] == 4'h0);
        flg.ovf = (opnd == 8'h80);
    end
endmodule
`default_nettype wire

/* sim/ext_decode_core_assertions.sv */
// Bus-side checks of the decode core.
// Assumes only the core's own ports are visible.
`timescale 1ns/1ps
`default_nettype none
module ext_decode_core_assertions
    import ext_decode_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
        else $error("ack without request");
    AST_RESET_QUIET: assert property ($rose(nrst) |-> !ack_o && dat_o == 32'h0)
        else $error("bus not quiet after reset");
    AST_DATA_HOLD: assert property ((!ack_o || $past(we_i)) |-> $stable(dat_o))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property (ack_o && $past(!we_i && adr_i[7:2] > 6'h0E)
        |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_STAT_CLOCKS: assert property (ack_o && $past(!we_i && adr_i[7:2] == 6'h01)
        |-> dat_o[0] || dat_o[15:8] inside {8'h00, 8'h04, 8'h08})
        else $error("clock count not 4 or 8");
    AST_PTR_WIDTH: assert property (ack_o && $past(!we_i && adr_i[7:2] inside {6'h07, 6'h08, 6'h09})
        |-> dat_o[31:12] == 20'h0)
        else $error("pointer wider than 12 bits");
endmodule
bind ext_decode_core ext_decode_core_assertions ext_decode_core_assertions_inst (
    .core_clk(core_clk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o));
`default_nettype wire

/* sim/ext_decode_core_test.sv */
// Self-checking bench of the decode core.
// Assumes the core answers every bus request; the bench is the master.
`timescale 1ns/1ps
`default_nettype none
module ext_decode_core_test
    import ext_decode_pkg::*;
;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] q;
    int mismatches = 0;
    int checked = 0;
    always #5 core_clk = ~core_clk;
    ext_decode_core ext_decode_core_inst (.core_clk(core_clk), .nrst(nrst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
        .dat_i(dat), .ack_o(ack), .dat_o(rdat));
    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // The wait is bounded so a silent slave ends the run cleanly.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            mismatches++;
            test_done();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic ck(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(q, e);
    endtask
    task automatic mem(input logic [11:0] a, input logic [7:0] v);
        wr(OFS_DADDR, {20'h0, a});
        wr(OFS_DDATA, {24'h0, v});
    endtask
    task automatic ckm(input logic [11:0] a, input logic [7:0] v);
        wr(OFS_DADDR, {20'h0, a});
        ck(OFS_DDATA, {24'h0, v});
    endtask
    task automatic ex(input logic x, input logic [15:0] w1, w2,
        input logic [7:0] c, input logic il);
        int n;
        wr(OFS_WORD1, {16'h0, w1});
        wr(OFS_WORD2, {16'h0, w2});
        wr(OFS_CTRL, {30'h0, x, 1'b1});
        n = 0;
        do begin
            bus(1'b0, OFS_STAT, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 40);
        if (q[0] !== 1'b0) begin
            mismatches++;
            test_done();
        end
        if (il) begin
            cmp({31'h0, q[1]}, 32'h1);
        end else begin
            cmp(q, {16'h0, c, 8'h00});
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        ck(OFS_CTRL, 32'h0);
        ck(OFS_PTR2, 32'h0);
        wr(8'h3C, 32'h5A);
        ck(8'h3C, 32'h0);
        $display("done reset");
    endtask
    task automatic t_negate;
        logic [7:0] opnd [3] = '{8'h3A, 8'h00, 8'h80};
        logic [7:0] res [3] = '{8'hC6, 8'h00, 8'h80};
        logic [7:0] flg [3] = '{8'h10, 8'h07, 8'h1A};
        wr(OFS_WORK, 32'h55);
        for (int i = 0; i < 3; i++) begin
            mem(12'h010 + 12'(i), opnd[i]);
            ex(1'b0, 16'h6C10 + 16'(i), 16'h0, 8'h04, 1'b0);
            ckm(12'h010 + 12'(i), res[i]);
            ck(OFS_FLAGS, {24'h0, flg[i]});
        end
        ck(OFS_WORK, 32'h55);
        ck(OFS_PC, 32'h6);
        $display("done negate");
    endtask
    task automatic t_address;
        wr(OFS_BANK, 32'h3);
        wr(OFS_PTR2, 32'h200);
        mem(12'h320, 8'h01);
        ex(1'b0, 16'h6D20, 16'h0, 8'h04, 1'b0);
        ckm(12'h320, 8'hFF);
        mem(12'hF80, 8'h02);
        ex(1'b1, 16'h6C80, 16'h0, 8'h04, 1'b0);
        ckm(12'hF80, 8'hFE);
        mem(12'h25F, 8'h04);
        ex(1'b1, 16'h6C5F, 16'h0, 8'h04, 1'b0);
        ckm(12'h25F, 8'hFC);
        mem(12'hF60, 8'h01);
        ex(1'b1, 16'h6C60, 16'h0, 8'h04, 1'b0);
        ckm(12'hF60, 8'hFF);
        mem(12'h05F, 8'h06);
        ex(1'b0, 16'h6C5F, 16'h0, 8'h04, 1'b0);
        ckm(12'h05F, 8'hFA);
        ckm(12'h25F, 8'hFC);
        $display("done address");
    endtask
    task automatic t_pointer;
        wr(OFS_FLAGS, 32'h1F);
        wr(OFS_PTR1, 32'h010);
        ex(1'b1, 16'hE87F, 16'h0, 8'h04, 1'b0);
        ck(OFS_PTR1, 32'h04F);
        wr(OFS_PTR0, 32'h010);
        ex(1'b1, 16'hE901, 16'h0, 8'h04, 1'b0);
        ck(OFS_PTR0, 32'h00F);
        wr(OFS_STACK, 32'h1234);
        wr(OFS_PTR2, 32'h100);
        ex(1'b1, 16'hE8C5, 16'h0, 8'h08, 1'b0);
        ck(OFS_PTR2, 32'h105);
        ck(OFS_PC, 32'h1234);
        wr(OFS_STACK, 32'h2000);
        ex(1'b1, 16'hE9C5, 16'h0, 8'h08, 1'b0);
        ck(OFS_PTR2, 32'h100);
        ck(OFS_PC, 32'h2000);
        ck(OFS_FLAGS, 32'h1F);
        $display("done pointer");
    endtask
    task automatic t_call_push;
        wr(OFS_PC, 32'h100);
        wr(OFS_PCLAT, 32'h12);
        wr(OFS_WORK, 32'h34);
        ex(1'b1, OPC_CALLWORK, 16'h0, 8'h08, 1'b0);
        ck(OFS_PC, 32'h1234);
        ck(OFS_STACK, 32'h0100_0102);
        wr(OFS_PTR2, 32'h080);
        ex(1'b1, 16'hEA5A, 16'h0, 8'h04, 1'b0);
        ckm(12'h080, 8'h5A);
        ck(OFS_PTR2, 32'h07F);
        $display("done call push");
    endtask
    task automatic t_move;
        wr(OFS_PTR2, 32'h100);
        wr(OFS_PC, 32'h0);
        mem(12'h105, 8'h77);
        ex(1'b1, 16'hEB05, 16'hF300, 8'h08, 1'b0);
        ckm(12'h300, 8'h77);
        ck(OFS_PC, 32'h4);
        ex(1'b1, 16'hEB85, 16'hF00A, 8'h08, 1'b0);
        ckm(12'h10A, 8'h77);
        ex(1'b1, 16'hEB05, 16'h0300, 8'h00, 1'b1);
        $display("done move");
    endtask
    task automatic t_refuse_idle;
        wr(OFS_PTR2, 32'h080);
        wr(OFS_PC, 32'h10);
        wr(OFS_FLAGS, 32'h0A);
        ex(1'b0, 16'hEA5A, 16'h0, 8'h00, 1'b1);
        ex(1'b0, OPC_CALLWORK, 16'h0, 8'h00, 1'b1);
        ck(OFS_PTR2, 32'h080);
        ck(OFS_PC, 32'h14);
        ex(1'b1, OPC_IDLE, 16'h0, 8'h04, 1'b0);
        ex(1'b1, 16'hF123, 16'h0, 8'h04, 1'b0);
        ck(OFS_PC, 32'h18);
        ck(OFS_FLAGS, 32'h0A);
        ck(OFS_PTR2, 32'h080);
        $display("done refuse idle");
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_negate();
        t_address();
        t_pointer();
        t_call_push();
        t_move();
        t_refuse_idle();
        test_done();
    end
endmodule
`default_nettype wire
